// File: hdl/ire_endec.v
/*
 Infrared line coder between a UART and an infrared transceiver, with the
 16x baud tick generator and an 8-entry transmit bit buffer.
 Assumes: all inputs synchronous to ref_clk; the UART offers its serial
 bits one per bit period over a valid/ready pair while the coder is on.
*/
`timescale 1ns/100ps
`include "ire_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO
module ire_fifo #(
	parameter WIDTH = `IRE_FIFO_W,
	parameter DEPTH = `IRE_FIFO_DEPTH,
	parameter AW = `IRE_FIFO_AW
) (
	input wire ref_clk,
	input wire nrst,
	input wire flush,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] level_q;
	wire push;
	wire pop;
	genvar gi;
	localparam [AW:0] FULL = DEPTH;

	assign in_ready = (level_q != FULL);
	assign out_valid = (level_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage entries
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
			localparam [AW-1:0] IDX = gi;
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					mem_q[gi] <= {WIDTH{1'b0}};
				end else if (push && wr_q == IDX) begin
					mem_q[gi] <= in_data;
				end
			end
		end
	endgenerate

	// Pointers and fill level
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			level_q <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			level_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				level_q <= level_q + 1'b1;
			end else if (pop && !push) begin
				level_q <= level_q - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - With coder on, encode UART output to the pin and decode pin input.
// - Half duplex: never transmit and receive at the same time.
// - Bit rate is clock divided by sixteen times the divisor.
// - Rates 9600 to 115.2 kbaud supported; faster divisors allowed.
// - Every bit spans sixteen baud clocks in both directions.
// - A one is sent as low for the whole sixteen clocks.
// - A zero is sent as low seven, high three, low six clocks.
// - With coder on, only the modulated signal reaches the transmit pin.
// - Decoder keeps a 0 to 15 baud clock counter for output and window.
// - Decoded stream lags the infrared stream by eight baud clocks.
// - A falling edge on the input while idle or inside the window resets the decoder counter.
// - At count eight the UART receive input takes the decoded bit.
// - Window opens at count twelve, closes at eight of next lap.
// - No pulse in window: bit is one, return idle, await falling edge.
// - Resynchronising the decoder never disturbs the UART receiver.
module ire_endec (
	input wire ref_clk,
	input wire nrst,
	input wire uart_enable,
	input wire infrared_coder_enable,
	input wire [`IRE_DIV_W-1:0] baud_divisor,
	input wire uart_txd,
	input wire tx_bit_data,
	input wire tx_bit_valid,
	output reg tx_bit_ready,
	output reg txd_pin,
	input wire rxd_pin,
	output reg uart_rxd,
	output reg baud_tick,
	output reg tx_busy,
	output reg rx_busy
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	localparam TX_IDLE = 1'b0;
	localparam TX_SEND = 1'b1;
	reg [`IRE_DIV_W-1:0] div_cnt_q;
	reg [`IRE_CNT_W-1:0] tx_cnt_q;
	reg tx_bit_q;
	reg tx_act_q;
	reg [`IRE_CNT_W-1:0] rx_cnt_q;
	reg rx_act_q;
	reg rx_lap_q;
	reg rx_bit_q;
	reg rx_prev_q;
	reg [`IRE_CNT_W-1:0] tx_cnt_d;
	reg tx_bit_d;
	reg tx_act_d;
	reg tx_pop;
	wire coder_on;
	wire buf_push;
	wire rx_update;
	wire tick;
	wire buf_valid;
	wire buf_data;
	wire buf_ready;
	wire buf_in_ready;
	wire tx_pend;
	wire rx_fall;
	wire rx_window;
	wire tx_pulse;

	assign coder_on = uart_enable & infrared_coder_enable;
	assign tick = baud_tick;

	////////////////////////////////////////////////////////////////////////////
	// Baud divisor generator: one tick per divisor clocks
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_q <= `IRE_DIV_RESET;
			baud_tick <= 1'b0;
		end else if (!uart_enable || baud_divisor == `IRE_DIV_RESET) begin
			div_cnt_q <= `IRE_DIV_RESET;
			baud_tick <= 1'b0;
		end else if (div_cnt_q <= 16'h0001) begin
			div_cnt_q <= baud_divisor;
			baud_tick <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - 16'h0001;
			baud_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit bit buffer
	assign buf_ready = tx_pop;
	assign buf_push = tx_bit_valid & tx_bit_ready & coder_on;

	// Ready from a flop; low for one cycle after each accepted bit
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_bit_ready <= 1'b0;
		end else begin
			tx_bit_ready <= coder_on & buf_in_ready & ~buf_push;
		end
	end

	ire_fifo #(
		.WIDTH(`IRE_FIFO_W),
		.DEPTH(`IRE_FIFO_DEPTH),
		.AW(`IRE_FIFO_AW)
	) u_fifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.flush(~coder_on),
		.in_data(tx_bit_data),
		.in_valid(buf_push),
		.in_ready(buf_in_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	assign tx_pend = buf_valid | tx_act_q;

	////////////////////////////////////////////////////////////////////////////
	// Encoder: sixteen ticks per bit, pulse in ticks 7..9 for a zero
	// Next bit loads on the tick after count 15, so bits stay 16 ticks apart
	always @* begin
		tx_act_d = tx_act_q;
		tx_cnt_d = tx_cnt_q;
		tx_bit_d = tx_bit_q;
		tx_pop = 1'b0;
		if (!coder_on) begin
			tx_act_d = TX_IDLE;
			tx_cnt_d = `IRE_CNT_ZERO;
			tx_bit_d = 1'b1;
		end else if (tick) begin
			case (tx_act_q)
				TX_IDLE: begin
					if (buf_valid && !rx_act_q) begin
						tx_pop = 1'b1;
						tx_act_d = TX_SEND;
						tx_cnt_d = `IRE_CNT_ZERO;
						tx_bit_d = buf_data;
					end
				end
				TX_SEND: begin
					if (tx_cnt_q != `IRE_CNT_LAST) begin
						tx_cnt_d = tx_cnt_q + 1'b1;
					end else if (buf_valid) begin
						tx_pop = 1'b1;
						tx_cnt_d = `IRE_CNT_ZERO;
						tx_bit_d = buf_data;
					end else begin
						tx_act_d = TX_IDLE;
						tx_cnt_d = `IRE_CNT_ZERO;
					end
				end
				default: begin
					tx_act_d = TX_IDLE;
				end
			endcase
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_cnt_q <= `IRE_CNT_ZERO;
			tx_bit_q <= 1'b1;
			tx_act_q <= TX_IDLE;
		end else begin
			tx_cnt_q <= tx_cnt_d;
			tx_bit_q <= tx_bit_d;
			tx_act_q <= tx_act_d;
		end
	end

	assign tx_pulse = tx_act_q & ~tx_bit_q
		& (tx_cnt_q >= `IRE_TX_PULSE_FIRST) & (tx_cnt_q <= `IRE_TX_PULSE_LAST);

	// Transmit pin: modulated when on, raw UART when off
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txd_pin <= `IRE_PIN_RESET;
		end else if (coder_on) begin
			txd_pin <= tx_pulse;
		end else begin
			txd_pin <= uart_txd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoder: resynchronising counter and sampling window
	assign rx_fall = rx_prev_q & ~rxd_pin;
	assign rx_update = tick & rx_act_q & (rx_cnt_q + 1'b1 == `IRE_RX_UPDATE_CNT);
	assign rx_window = rx_lap_q | (rx_cnt_q >= `IRE_RX_WINDOW_CNT);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rxd_pin;
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_cnt_q <= `IRE_CNT_ZERO;
			rx_act_q <= 1'b0;
			rx_lap_q <= 1'b0;
			rx_bit_q <= `IRE_UART_IDLE;
		end else if (!coder_on || tx_pend) begin
			rx_cnt_q <= `IRE_CNT_ZERO;
			rx_act_q <= 1'b0;
			rx_lap_q <= 1'b0;
			rx_bit_q <= `IRE_UART_IDLE;
		end else if (rx_fall && (!rx_act_q || rx_window)) begin
			rx_cnt_q <= `IRE_CNT_ZERO;
			rx_act_q <= 1'b1;
			rx_lap_q <= 1'b0;
			rx_bit_q <= 1'b0;
		end else if (tick && rx_act_q) begin
			rx_cnt_q <= rx_cnt_q + 1'b1;
			if (rx_cnt_q == `IRE_CNT_LAST) begin
				rx_lap_q <= 1'b1;
			end
			if (rx_cnt_q + 1'b1 == `IRE_RX_UPDATE_CNT) begin
				if (rx_lap_q) begin
					rx_act_q <= 1'b0;
					rx_lap_q <= 1'b0;
					rx_cnt_q <= `IRE_CNT_ZERO;
				end
				rx_bit_q <= `IRE_UART_IDLE;
			end
		end
	end

	// UART receive input: decoded when on, raw pin when off
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			uart_rxd <= `IRE_UART_IDLE;
		end else if (!coder_on) begin
			uart_rxd <= rxd_pin;
		end else if (tx_pend) begin
			uart_rxd <= `IRE_UART_IDLE;
		end else if (rx_update) begin
			uart_rxd <= rx_lap_q ? `IRE_UART_IDLE : rx_bit_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_busy <= 1'b0;
			rx_busy <= 1'b0;
		end else begin
			tx_busy <= coder_on & tx_pend;
			rx_busy <= coder_on & rx_act_q;
		end
	end
endmodule

// File: inc/ire_defines.vh
/*
 Constants for the infrared line coder: bit timing in 16x baud ticks,
 receive window positions, buffer geometry and reset levels.
 Assumes inclusion by bare name from the design file.
*/
`ifndef IRE_DEFINES_VH
`define IRE_DEFINES_VH

// Baud divisor width
`define IRE_DIV_W 16
// Ticks per data bit and the counter width
`define IRE_BIT_TICKS 16
`define IRE_CNT_W 4
`define IRE_CNT_LAST 4'hF
`define IRE_CNT_ZERO 4'h0
// Encoder: low 7, high 3, low 6
`define IRE_TX_LOW_LEAD 4'h7
`define IRE_TX_HIGH_LEN 4'h3
`define IRE_TX_PULSE_FIRST 4'h7
`define IRE_TX_PULSE_LAST 4'h9
// Decoder: output update and window opening counts
`define IRE_RX_UPDATE_CNT 4'h8
`define IRE_RX_WINDOW_CNT 4'hC
// Transmit bit buffer
`define IRE_FIFO_W 1
`define IRE_FIFO_DEPTH 8
`define IRE_FIFO_AW 3
// Reset levels
`define IRE_UART_IDLE 1'b1
`define IRE_PIN_RESET 1'b0
`define IRE_DIV_RESET 16'h0000

`endif

// File: verif/ire_props.sv
/*
 Port checker for the infrared line coder, bound to every instance.
 Assumes timing checks run with a divisor of 3 and a steady UART enable.
*/
`timescale 1ns/100ps
module ire_props (
	input wire ref_clk,
	input wire nrst,
	input wire uart_enable,
	input wire infrared_coder_enable,
	input wire [15:0] baud_divisor,
	input wire uart_txd,
	input wire tx_bit_data,
	input wire tx_bit_valid,
	input wire tx_bit_ready,
	input wire txd_pin,
	input wire rxd_pin,
	input wire uart_rxd,
	input wire baud_tick,
	input wire tx_busy,
	input wire rx_busy
);
	wire ir_on;
	assign ir_on = uart_enable & infrared_coder_enable;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	pass_tx_a: assert property ($past(nrst) && !$past(ir_on) |-> txd_pin == $past(uart_txd))
		else $error("transmit pin not following uart");
	pass_rx_a: assert property ($past(nrst) && !$past(ir_on) |-> uart_rxd == $past(rxd_pin))
		else $error("uart input not following pin");
	tick_idle_a: assert property (!uart_enable && !$past(uart_enable) |-> !baud_tick)
		else $error("tick while uart off");
	tick_gap_a: assert property (baud_tick && uart_enable && baud_divisor == 16'h0003 |=>
		!baud_tick ##1 !baud_tick ##1 baud_tick) else $error("tick spacing wrong");
	ready_off_a: assert property (!ir_on && !$past(ir_on) |-> !tx_bit_ready)
		else $error("buffer ready with coder off");
	pulse_len_a: assert property (ir_on && $rose(txd_pin) && baud_divisor == 16'h0003 |->
		txd_pin [*8] ##1 txd_pin ##1 !txd_pin) else $error("pulse length wrong");
	pulse_gap_a: assert property (ir_on && $fell(txd_pin) |-> !txd_pin [*8])
		else $error("pulse gap too short");
	rx_hold_a: assert property (ir_on && $past(tx_busy) && tx_busy |-> uart_rxd)
		else $error("receive active while sending");
	tx_rx_a: assert property (ir_on && txd_pin |-> !rx_busy)
		else $error("send and receive overlap");
	rx_lag_a: assert property (ir_on && !rx_busy && !tx_busy && $fell(rxd_pin) && baud_divisor == 16'h0003 |->
		uart_rxd [*8] ##[12:19] !uart_rxd) else $error("decoded bit late or early");
	cover property ($rose(txd_pin));
	cover property (ir_on && $fell(uart_rxd));
	cover property (ir_on && tx_bit_valid && !tx_bit_ready);
endmodule

bind ire_endec ire_props chk (.*);

// File: verif/ire_xcvr_model.sv
/*
 Behavioural infrared transceiver: pulses toward the coder, counts lit clocks.
 Assumes the testbench paces its pulses on ref_clk.
*/
`timescale 1ns/100ps
module ire_xcvr_model (
	input wire ref_clk,
	input wire txd_pin,
	output wire rxd_pin
);
	logic rx_q = 1'b1;
	int light_clocks = 0;
	assign rxd_pin = rx_q;
	// Emitter lit time
	always @(posedge ref_clk) begin
		if (txd_pin === 1'b1) begin
			light_clocks <= light_clocks + 1;
		end
	end
	// Line level, idle high
	task drive(input logic v);
		rx_q = v;
	endtask
endmodule

// File: verif/testbench.sv
/*
 Self-checking bench for the infrared line coder with a transceiver model.
 Assumes a 200 MHz clock and a divisor of 3 clocks per tick.
*/
`timescale 1ns/100ps
module testbench;
	logic ref_clk;
	logic nrst;
	logic uart_enable;
	logic infrared_coder_enable;
	logic [15:0] baud_divisor;
	logic uart_txd;
	logic tx_bit_data;
	logic tx_bit_valid;
	wire tx_bit_ready, txd_pin, rxd_pin, uart_rxd, baud_tick, tx_busy, rx_busy;
	int error_cnt = 0;
	int samples_checked = 0;
	ire_endec dut (.*);
	ire_xcvr_model xcvr (.*);
	always #2.5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////////
	task go();
		@(posedge ref_clk);
		#1;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
			error_cnt++;
		end
	endtask
	task test_done();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task push(input logic b);
		tx_bit_data = b;
		tx_bit_valid = 1'b1;
		do @(posedge ref_clk); while (tx_bit_ready !== 1'b1);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_bypass();
		for (int v = 0; v < 2; v++) begin
			uart_txd = v[0];
			xcvr.drive(v[0]);
			go();
			go();
			check(txd_pin, v[0]);
			check(uart_rxd, v[0]);
			check(tx_bit_ready, 1'b0);
		end
	endtask
	task t_tx();
		int k;
		int lit;
		logic [8:0] bits;
		bits = 9'h0FE;
		lit = xcvr.light_clocks;
		for (k = 0; k < 9; k++) push(bits[k]);
		tx_bit_valid = 1'b0;
		check(tx_bit_ready, 1'b0);
		k = 0;
		while (tx_busy !== 1'b0 && k < 700) begin
			go();
			k++;
		end
		check(tx_busy, 1'b0);
		check(xcvr.light_clocks - lit, 18);
	endtask
	task t_rx();
		int n;
		int t0;
		int t1;
		t0 = 0;
		t1 = 0;
		xcvr.drive(1'b0);
		for (n = 1; n <= 140; n++) begin
			@(posedge ref_clk);
			#1;
			if (uart_rxd === 1'b0 && t0 == 0) t0 = n;
			if (n == 108) check(uart_rxd, 1'b0);
			if (uart_rxd === 1'b1 && t0 != 0 && t1 == 0) t1 = n;
			if (n == 9 || n == 57) xcvr.drive(1'b1);
			if (n == 48) xcvr.drive(1'b0);
		end
		check(t0 >= 22 && t0 <= 28, 1'b1);
		check(t1 >= 118 && t1 <= 126, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		uart_enable = 1'b0;
		infrared_coder_enable = 1'b0;
		baud_divisor = 16'h0000;
		uart_txd = 1'b1;
		tx_bit_data = 1'b0;
		tx_bit_valid = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		baud_divisor = 16'h0003;
		go();
		uart_enable = 1'b1;
		t_bypass();
		infrared_coder_enable = 1'b1;
		go();
		go();
		check(txd_pin, 1'b0);
		t_tx();
		go();
		t_rx();
		test_done();
	end
	initial begin
		#10000;
		error_cnt++;
		test_done();
	end
endmodule
